// file: shared/tbops_pkg.sv
// Purpose: constants for the 10Base-T operations register block
// Assumes: 10 MHz sys_clk, management access by register index
// Notes: times are given in their own unit, cycle counts derived here
`default_nettype none
package tbops_pkg;
    // ********************************
    // register map
    // ********************************
    localparam logic [4:0] TBOPS_REG_INDEX = 5'h12;
    localparam int TBOPS_BIT_RJAB = 15;
    localparam int TBOPS_BIT_POL = 14;
    localparam int TBOPS_BIT_JAB_INH = 5;
    localparam int TBOPS_BIT_APOL_INH = 3;
    localparam int TBOPS_BIT_SQE_INH = 2;
    localparam int TBOPS_BIT_LLOSS_INH = 1;
    localparam int TBOPS_BIT_SQL_INH = 0;
    // writable bits 13:0, reserved bit 4 defaults to one
    localparam logic [13:0] TBOPS_CTRL_RESET = 14'h0010;

    // ********************************
    // timing
    // ********************************
    localparam int TBOPS_CLK_MHZ = 10;
    localparam int TBOPS_JABBER_TIME_US = 20000;
    localparam int TBOPS_JABBER_CYCLES = TBOPS_JABBER_TIME_US * TBOPS_CLK_MHZ;
    localparam int TBOPS_SQE_DELAY_NS = 800;
    localparam int TBOPS_SQE_WIDTH_NS = 1000;
    // least times, rounded up to whole cycles
    localparam int TBOPS_SQE_DELAY_CYC = (TBOPS_SQE_DELAY_NS * TBOPS_CLK_MHZ + 999) / 1000;
    localparam int TBOPS_SQE_WIDTH_CYC = (TBOPS_SQE_WIDTH_NS * TBOPS_CLK_MHZ + 999) / 1000;
    localparam logic [4:0] TBOPS_SQE_WIDTH = 5'(TBOPS_SQE_WIDTH_CYC);
    localparam logic [4:0] TBOPS_SQE_TOTAL = 5'(TBOPS_SQE_DELAY_CYC + TBOPS_SQE_WIDTH_CYC);

    // link establishment states
    typedef enum logic [1:0]
    {
        TBOPS_LNK_DOWN = 2'b00,
        TBOPS_LNK_WAIT_IDLE = 2'b01,
        TBOPS_LNK_UP = 2'b10
    } tbops_link_t;
endpackage // tbops_pkg
`default_nettype wire

// file: hdl/tbops_jab_timer.sv
// Purpose: activity length timer flagging a jabber condition
// Assumes: active already synchronised to sys_clk
// Notes: expired stays high until activity ends
`timescale 1ns/1ns
`default_nettype none
module tbops_jab_timer
    import tbops_pkg::*;
#(
    parameter logic [17:0] LIMIT = 18'(TBOPS_JABBER_CYCLES)
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic active,
    output logic expired
);
    logic [17:0] count; // cycles of unbroken activity
    wire logic at_limit = (count >= LIMIT);

    // ********************************
    // counter, restarts on every gap
    // ********************************
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            count <= 18'h00000;
            expired <= 1'b0;
        end
        else if (!active)
        begin
            count <= 18'h00000;
            expired <= 1'b0;
        end
        else
        begin
            // saturate so a long jabber never wraps
            if (!at_limit)
                count <= count + 18'h00001;
            expired <= at_limit;
        end
    end
endmodule // tbops_jab_timer
`default_nettype wire

// file: hdl/tbops_ctrl.sv
// Purpose: 10Base-T operations register with its monitor and control logic
// Assumes: management read is a start strobe, then a done strobe
// Notes: pin-side receive indications pass a two-flop synchroniser
`timescale 1ns/1ns
`default_nettype none
module tbops_ctrl
    import tbops_pkg::*;
#(
    parameter logic [17:0] JABBER_CYCLES = 18'(TBOPS_JABBER_CYCLES)
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [4:0] mgmt_addr,
    input wire logic mgmt_wr,
    input wire logic [15:0] mgmt_wdata,
    input wire logic mgmt_rd,
    input wire logic mgmt_rd_done,
    output logic [15:0] mgmt_rdata,
    input wire logic ten_mode,
    input wire logic full_duplex,
    input wire logic repeater_mode,
    input wire logic amdix_enabled,
    input wire logic tx_en,
    input wire logic rx_activity,
    input wire logic rx_pol_reversed,
    input wire logic rx_valid_data,
    input wire logic idle_pattern,
    input wire logic rx_link_fail,
    output logic sqe_collision,
    output logic tx_jabber,
    output logic polarity_correct,
    output logic link_pass
);
    // ********************************
    // pin synchronisers
    // ********************************
    wire logic [4:0] pin_raw = {rx_link_fail, idle_pattern, rx_valid_data, rx_pol_reversed, rx_activity};
    logic [4:0] sync_a; // first stage, read by second only
    logic [4:0] sync_b; // safe copies
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_sync
            always_ff @(posedge sys_clk or posedge rst)
            begin
                if (rst)
                begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                end
                else
                begin
                    sync_a[gi] <= pin_raw[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate
    wire logic rx_act_s = sync_b[0];
    wire logic pol_rev_s = sync_b[1];
    wire logic valid_s = sync_b[2];
    wire logic idle_s = sync_b[3];
    wire logic fail_s = sync_b[4];

    // ********************************
    // register decode
    // ********************************
    logic [13:0] ctrl; // writable bits, reserved kept as written
    logic rjab; // latched remote jabber
    logic pol; // latched polarity reversal
    logic [1:0] snap; // latched bits returned by the open read
    wire logic hit = (mgmt_addr == TBOPS_REG_INDEX);
    wire logic wr_hit = mgmt_wr & hit;
    wire logic rd_hit = mgmt_rd & hit;
    wire logic jab_inh = ctrl[TBOPS_BIT_JAB_INH];
    wire logic apol_inh = ctrl[TBOPS_BIT_APOL_INH];
    wire logic sqe_inh = ctrl[TBOPS_BIT_SQE_INH];
    wire logic lloss_inh = ctrl[TBOPS_BIT_LLOSS_INH];
    wire logic sql_inh = ctrl[TBOPS_BIT_SQL_INH];

    // ********************************
    // jabber timers
    // ********************************
    logic rx_jab_exp; // receive path over the jabber limit
    logic tx_jab_exp; // transmit path over the jabber limit
    // same transmit criteria, applied to receive activity
    tbops_jab_timer #(.LIMIT(JABBER_CYCLES)) u_rx_jab
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .active(rx_act_s & ten_mode),
        .expired(rx_jab_exp)
    );
    tbops_jab_timer #(.LIMIT(JABBER_CYCLES)) u_tx_jab
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .active(tx_en & ten_mode),
        .expired(tx_jab_exp)
    );

    // latched status sources, only in 10Base-T mode
    wire logic rjab_set = rx_jab_exp & ten_mode;
    wire logic pol_set = pol_rev_s & ten_mode;
    // a bit clears only if it went out in the finished read
    wire logic rjab_clr = mgmt_rd_done & snap[1];
    wire logic pol_clr = mgmt_rd_done & snap[0];
    wire logic [15:0] rd_word = {rjab, pol, ctrl};

    // ********************************
    // control and status storage
    // ********************************
    // control bits change only on a write, never from suppression
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            ctrl <= TBOPS_CTRL_RESET;
        else if (wr_hit)
            ctrl <= mgmt_wdata[13:0];
    end

    // set wins over clear, so an event during a read survives
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rjab <= 1'b0;
            pol <= 1'b0;
        end
        else
        begin
            rjab <= rjab_set | (rjab & ~rjab_clr);
            pol <= pol_set | (pol & ~pol_clr);
        end
    end

    // read data and snapshot of what was returned
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            mgmt_rdata <= 16'h0000;
            snap <= 2'b00;
        end
        else if (rd_hit)
        begin
            mgmt_rdata <= rd_word;
            // an event on the snapshot edge itself is not yet reported
            snap <= {rjab & ~rjab_set, pol & ~pol_set};
        end
        else if (mgmt_rd_done)
            snap <= 2'b00;
        else
            // a fresh event while the read is open must survive its close
            snap <= snap & ~{rjab_set, pol_set};
    end

    // ********************************
    // transmit jabber and polarity
    // ********************************
    // remote jabber drives nothing here, it is only reported
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tx_jabber <= 1'b0;
            polarity_correct <= 1'b0;
        end
        else
        begin
            tx_jabber <= ten_mode & ~jab_inh & tx_jab_exp;
            // crossover search stalls on an inverted cable
            polarity_correct <= ten_mode & pol_rev_s & ~apol_inh & ~amdix_enabled;
        end
    end

    // ********************************
    // SQE test
    // ********************************
    logic tx_en_q; // previous transmit enable
    logic [4:0] sqe_cnt; // delay then pulse, counting down
    wire logic tx_fall = tx_en_q & ~tx_en;
    wire logic sqe_allow = ten_mode & ~sqe_inh & ~full_duplex & ~repeater_mode;
    wire logic sqe_busy = (sqe_cnt != 5'h00);
    wire logic sqe_in_pulse = sqe_busy & (sqe_cnt <= TBOPS_SQE_WIDTH);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tx_en_q <= 1'b0;
            sqe_cnt <= 5'h00;
            sqe_collision <= 1'b0;
        end
        else
        begin
            tx_en_q <= tx_en;
            if (tx_fall & sqe_allow)
                sqe_cnt <= TBOPS_SQE_TOTAL;
            else if (sqe_busy)
                sqe_cnt <= sqe_cnt - 5'h01;
            // mode change mid test cuts the pulse at once
            sqe_collision <= sqe_in_pulse & sqe_allow;
        end
    end

    // ********************************
    // link establishment
    // ********************************
    tbops_link_t link_st; // link integrity state
    tbops_link_t next_link_st; // next state
    always_comb
    begin
        next_link_st = link_st;
        unique case (link_st)
            TBOPS_LNK_DOWN:
                if (valid_s)
                    next_link_st = sql_inh ? TBOPS_LNK_WAIT_IDLE : TBOPS_LNK_UP;
            TBOPS_LNK_WAIT_IDLE:
                if (fail_s)
                    next_link_st = TBOPS_LNK_DOWN;
                else if (idle_s)
                    next_link_st = TBOPS_LNK_UP;
            TBOPS_LNK_UP:
                if (fail_s)
                    next_link_st = TBOPS_LNK_DOWN;
            default:
                next_link_st = TBOPS_LNK_DOWN;
        endcase
        if (!ten_mode)
            next_link_st = TBOPS_LNK_DOWN;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            link_st <= TBOPS_LNK_DOWN;
            link_pass <= 1'b0;
        end
        else
        begin
            link_st <= next_link_st;
            link_pass <= ten_mode & (lloss_inh | (link_st == TBOPS_LNK_UP));
        end
    end

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_read_open;
        rd_hit & rjab & ~rjab_set;
    endsequence
    sequence s_read_close;
        mgmt_rd_done & ~rjab_set & ~rd_hit;
    endsequence

    rjab_read_clear_a: assert property (s_read_open ##1 s_read_close |=> !rjab)
        else $error("remote jabber not cleared after read");
    rjab_set_wins_a: assert property (rjab_set |=> rjab)
        else $error("remote jabber event lost");
    rjab_hold_a: assert property (rjab & !mgmt_rd_done |=> rjab)
        else $error("remote jabber dropped without read");
    pol_latch_a: assert property (pol_set |=> pol ##1 (pol || $past(mgmt_rd_done)))
        else $error("polarity reversal not latched");
    jab_inhibit_a: assert property (jab_inh && $past(jab_inh) |-> !tx_jabber)
        else $error("transmit jabber while inhibited");
    sqe_pulse_a: assert property (tx_fall & sqe_allow ##1 sqe_allow [*8] ##1 sqe_allow |=> sqe_collision)
        else $error("SQE pulse missing after transmit end");
    sqe_suppress_a: assert property (full_duplex || repeater_mode |=> !sqe_collision)
        else $error("SQE pulse in suppressed mode");
    sqe_bit_kept_a: assert property (!wr_hit |=> $stable(ctrl[TBOPS_BIT_SQE_INH]))
        else $error("SQE inhibit bit changed without write");
    link_forced_a: assert property (ten_mode & lloss_inh |=> link_pass)
        else $error("link not forced to pass");
    squelch_idle_a: assert property (link_st == TBOPS_LNK_WAIT_IDLE & ten_mode & ~idle_s & ~fail_s
        |=> link_st == TBOPS_LNK_WAIT_IDLE)
        else $error("link up without idle pattern");
    ten_only_a: assert property (!ten_mode |=> !link_pass && !tx_jabber && !polarity_correct)
        else $error("10Base-T function active outside 10Base-T mode");
endmodule // tbops_ctrl
`default_nettype wire

// file: tb/tbops_sta.sv
// Purpose: station management model driving the register strobes
// Assumes: strobes change just after a rising edge
// Notes: reserved bits always carry defaults on writes
`timescale 1ns/1ns
`default_nettype none
module tbops_sta
(
    input wire logic sys_clk,
    output logic [4:0] mgmt_addr,
    output logic mgmt_wr,
    output logic [15:0] mgmt_wdata,
    output logic mgmt_rd,
    output logic mgmt_rd_done,
    input wire logic [15:0] mgmt_rdata
);
    // ********
    // bus idle at time zero
    // ********
    initial
    begin
        mgmt_addr = 5'h00;
        mgmt_wr = 1'b0;
        mgmt_wdata = 16'h0000;
        mgmt_rd = 1'b0;
        mgmt_rd_done = 1'b0;
    end
    // write; read-only bits 15:14 pass so the device must ignore them
    task automatic wr(input logic [4:0] a, input logic [15:0] c);
        @(posedge sys_clk);
        mgmt_addr <= a;
        mgmt_wdata <= {c[15:14], 8'h00, c[5], 1'b1, c[3:0]};
        mgmt_wr <= 1'b1;
        @(posedge sys_clk);
        mgmt_wr <= 1'b0;
        mgmt_wdata <= ~mgmt_wdata; // stale data never lingers
    endtask
    // read; gap makes the completion prompt or slow
    task automatic rd(input logic [4:0] a, input int gap, output logic [15:0] d);
        @(posedge sys_clk);
        mgmt_addr <= a;
        mgmt_rd <= 1'b1;
        @(posedge sys_clk);
        mgmt_rd <= 1'b0;
        repeat (gap) @(posedge sys_clk);
        mgmt_rd_done <= 1'b1;
        @(posedge sys_clk);
        d = mgmt_rdata;
        mgmt_rd_done <= 1'b0;
    endtask
endmodule // tbops_sta
`default_nettype wire

// file: tb/tb.sv
// Purpose: self-checking bench for the operations register
// Assumes: short jabber limit, pin inputs need sync time
// Notes: model keeps control image and latch expectations
`timescale 1ns/1ns
`default_nettype none
module tb
    import tbops_pkg::*;
;
    localparam logic [17:0] JAB = 18'h00014; // short jabber limit
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ten_mode, full_duplex, repeater_mode, amdix_enabled, tx_en;
    logic rx_activity, rx_pol_reversed, rx_valid_data, idle_pattern, rx_link_fail;
    logic [4:0] mgmt_addr;
    logic mgmt_wr, mgmt_rd, mgmt_rd_done;
    logic [15:0] mgmt_wdata, mgmt_rdata, d;
    logic sqe_collision, tx_jabber, polarity_correct, link_pass;
    int err_total = 0;
    int n_compared = 0;
    integer seed = 74; // fixed seed
    int exp_ctrl = 16; // model control image
    logic rj_exp = 1'b0; // model remote jabber latch
    logic pol_exp = 1'b0; // model polarity latch
    int cnt;
    always #50 sys_clk = ~sys_clk;
    tbops_ctrl #(.JABBER_CYCLES(JAB)) i_tbops_ctrl (.sys_clk(sys_clk), .rst(rst), .mgmt_addr(mgmt_addr),
        .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata), .mgmt_rd(mgmt_rd), .mgmt_rd_done(mgmt_rd_done),
        .mgmt_rdata(mgmt_rdata), .ten_mode(ten_mode), .full_duplex(full_duplex), .repeater_mode(repeater_mode),
        .amdix_enabled(amdix_enabled), .tx_en(tx_en), .rx_activity(rx_activity), .rx_pol_reversed(rx_pol_reversed),
        .rx_valid_data(rx_valid_data), .idle_pattern(idle_pattern), .rx_link_fail(rx_link_fail),
        .sqe_collision(sqe_collision), .tx_jabber(tx_jabber), .polarity_correct(polarity_correct),
        .link_pass(link_pass));
    tbops_sta i_tbops_sta (.sys_clk(sys_clk), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata),
        .mgmt_rd(mgmt_rd), .mgmt_rd_done(mgmt_rd_done), .mgmt_rdata(mgmt_rdata));
    // ********
    // helpers
    // ********
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wrc(input logic [15:0] c);
        i_tbops_sta.wr(TBOPS_REG_INDEX, c);
        exp_ctrl = (c & 16'h002F) | 16'h0010;
        cyc(4);
    endtask
    task automatic rdc(input int gap);
        i_tbops_sta.rd(TBOPS_REG_INDEX, gap, d);
        chk_reg(d, {rj_exp, pol_exp, exp_ctrl[13:0]});
    endtask
    // one transmit burst, then count collision cycles
    task automatic sqe_run(input int width);
        @(posedge sys_clk);
        tx_en <= 1'b1;
        cyc(5);
        tx_en <= 1'b0;
        cnt = 0;
        repeat (30) @(negedge sys_clk) cnt += int'(sqe_collision === 1'b1);
        @(posedge sys_clk);
        chk_reg(16'(cnt), 16'(width));
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ********
    // main sequence
    // ********
    initial
    begin
        {ten_mode, full_duplex, repeater_mode, amdix_enabled, tx_en} = 5'h10;
        {rx_activity, rx_pol_reversed, rx_valid_data, idle_pattern, rx_link_fail} = 5'h00;
        cyc(8);
        rst <= 1'b0;
        rdc(0);
        full_duplex <= 1'b1; // control bits must not follow the mode
        repeat (6)
        begin
            wrc(16'($random(seed)));
            rdc(int'($random(seed) & 3));
        end
        full_duplex <= 1'b0;
        i_tbops_sta.wr(5'h13, 16'h002F); // foreign index ignored
        rdc(0);
        i_tbops_sta.rd(5'h11, 0, d);
        chk_reg(d, {rj_exp, pol_exp, exp_ctrl[13:0]});
        $display("test registers finished");
        wrc(16'h0000);
        rx_pol_reversed <= 1'b1;
        cyc(6);
        chk_reg(16'(polarity_correct), 16'h0001);
        pol_exp = 1'b1;
        rdc(0);
        wrc(16'h0008);
        chk_reg(16'(polarity_correct), 16'h0000);
        wrc(16'h0000);
        amdix_enabled <= 1'b1;
        cyc(4);
        chk_reg(16'(polarity_correct), 16'h0000);
        amdix_enabled <= 1'b0;
        rx_pol_reversed <= 1'b0;
        cyc(6);
        rdc(0);
        pol_exp = 1'b0;
        fork
            rdc(8);
            begin
                cyc(2);
                rx_pol_reversed <= 1'b1;
                cyc(2);
                rx_pol_reversed <= 1'b0;
            end
        join
        pol_exp = 1'b1;
        rdc(0);
        pol_exp = 1'b0;
        rdc(0);
        $display("test polarity finished");
        tx_en <= 1'b1;
        cyc(int'(JAB) + 10);
        chk_reg(16'(tx_jabber), 16'h0001);
        tx_en <= 1'b0;
        cyc(30);
        wrc(16'h0020);
        tx_en <= 1'b1;
        cyc(int'(JAB) + 10);
        chk_reg(16'(tx_jabber), 16'h0000);
        tx_en <= 1'b0;
        rx_activity <= 1'b1; // short burst stays under the limit
        cyc(int'(JAB) - 6);
        rx_activity <= 1'b0;
        cyc(4);
        rdc(0);
        wrc(16'h0000);
        rx_activity <= 1'b1;
        cyc(int'(JAB) + 10);
        chk_reg(16'({tx_jabber, link_pass, polarity_correct, sqe_collision}), 16'h0000);
        rx_activity <= 1'b0;
        cyc(4);
        rj_exp = 1'b1;
        rdc(0);
        rj_exp = 1'b0;
        rdc(0);
        $display("test jabber finished");
        sqe_run(TBOPS_SQE_WIDTH_CYC);
        wrc(16'h0004);
        sqe_run(0);
        wrc(16'h0000);
        full_duplex <= 1'b1;
        sqe_run(0);
        full_duplex <= 1'b0;
        repeater_mode <= 1'b1;
        sqe_run(0);
        repeater_mode <= 1'b0;
        $display("test sqe finished");
        wrc(16'h0002);
        rx_link_fail <= 1'b1;
        cyc(6);
        chk_reg(16'(link_pass), 16'h0001);
        wrc(16'h0000);
        chk_reg(16'(link_pass), 16'h0000);
        rx_link_fail <= 1'b0;
        rx_valid_data <= 1'b1;
        cyc(4);
        rx_valid_data <= 1'b0;
        cyc(6);
        chk_reg(16'(link_pass), 16'h0001);
        rx_link_fail <= 1'b1;
        cyc(4);
        rx_link_fail <= 1'b0;
        wrc(16'h0001);
        rx_valid_data <= 1'b1;
        cyc(4);
        rx_valid_data <= 1'b0;
        cyc(6);
        chk_reg(16'(link_pass), 16'h0000);
        idle_pattern <= 1'b1;
        cyc(4);
        idle_pattern <= 1'b0;
        cyc(6);
        chk_reg(16'(link_pass), 16'h0001);
        $display("test link finished");
        ten_mode <= 1'b0;
        rx_pol_reversed <= 1'b1;
        cyc(6);
        chk_reg(16'({link_pass, polarity_correct, tx_jabber}), 16'h0000);
        rx_pol_reversed <= 1'b0;
        sqe_run(0);
        rdc(0);
        $display("test mode finished");
        conclude();
    end
    // hang guard
    initial
    begin
        cyc(5000);
        err_total++;
        $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        conclude();
    end
endmodule // tb
`default_nettype wire
